// >>> lsat_agu_timing.sv
// Top of the load/store address-generation timing model.
// Assumes the issue stage holds a request until accepted and names the consumer's class.
`timescale 1ns/10ps
`default_nettype none
module lsat_agu_timing
  import lsat_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Memory operation issue
  input  wire logic       mem_valid,
  input  wire lsat_op_t   mem_op,
  input  wire logic [4:0] mem_reg_count,
  input  wire logic       mem_addr_aligned,
  input  wire logic       mem_offset_shift_reg,
  input  wire logic       mem_sign_extend,
  input  wire logic       mem_conditional,
  // Dependent consumer
  input  wire logic       use_valid,
  input  wire logic       use_dependent,
  input  wire logic       use_arith_logic_sat,
  input  wire logic       use_shift,
  // Status
  output logic            mem_ready,
  output logic            agu_busy,
  output logic            use_stall,
  output logic            use_forwarded,
  output logic            first_reg_ready,
  output logic [3:0]      last_agu_cycles
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {LSAT_IDLE, LSAT_GEN} lsat_state_t;

  typedef struct packed {
    lsat_state_t state;
    logic [3:0]  agu_left;
    logic [2:0]  lat_full;   // Latency of last load, no forwarding
    logic [2:0]  lat_age;    // Cycles since that load issued
    logic        lat_live;
    logic        fast_ok;    // Producer side allows the fast path
    logic        is_load;
    logic        mem_ready;
    logic        busy;
    logic        stall;
    logic        fwd;
    logic        first_rdy;
    logic [3:0]  last_cyc;
  } lsat_st_t;

  lsat_st_t st_q;
  lsat_st_t st_d;
  logic [3:0] calc_cycles;
  logic       accept;
  logic       fast_use;
  logic [2:0] need;

  lsat_cycle_calc u_calc (
    .op               (mem_op),
    .reg_count        (mem_reg_count),
    .addr_aligned     (mem_addr_aligned),
    .offset_shift_reg (mem_offset_shift_reg),
    .agu_cycles       (calc_cycles)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    st_d     = st_q;
    accept   = mem_valid && st_q.mem_ready;
    fast_use = st_q.fast_ok && use_arith_logic_sat && !use_shift;
    need     = fast_use ? 3'(st_q.lat_full - LSAT_LAT_FAST_SAVE) : st_q.lat_full;
    unique case (st_q.state)
      LSAT_IDLE: begin
        if (accept && calc_cycles > 4'h1) begin
          st_d.state    = LSAT_GEN;
          st_d.agu_left = 4'(calc_cycles - 4'h1);
        end
      end
      LSAT_GEN: begin
        st_d.agu_left = 4'(st_q.agu_left - 4'h1);
        if (st_q.agu_left == 4'h1) begin
          st_d.state = LSAT_IDLE;
        end
      end
    endcase
    if (st_q.lat_live && st_q.lat_age != 3'h7) begin
      st_d.lat_age = 3'(st_q.lat_age + 3'h1);
    end
    if (accept) begin
      st_d.last_cyc = calc_cycles;
      st_d.is_load  = (mem_op == LSAT_OP_LOAD_SINGLE || mem_op == LSAT_OP_LOAD_MULTIPLE ||
                       mem_op == LSAT_OP_LOAD_DOUBLEWORD || mem_op == LSAT_OP_RETURN_FROM_EXCEPTION);
      st_d.lat_live = st_d.is_load;
      st_d.lat_age  = 3'h1;
      // Latency counts to the first loaded register only
      st_d.lat_full = (mem_op == LSAT_OP_LOAD_SINGLE && mem_offset_shift_reg) ?
                      LSAT_LAT_SHIFTREG : LSAT_LAT_SIMPLE;
      st_d.fast_ok  = !mem_sign_extend && !mem_conditional;
    end
    st_d.mem_ready = (st_d.state == LSAT_IDLE);
    st_d.busy      = (st_d.state != LSAT_IDLE);
    st_d.stall     = use_valid && use_dependent && st_q.lat_live && (st_q.lat_age < need);
    st_d.fwd       = use_valid && use_dependent && st_q.lat_live && fast_use && (st_q.lat_age == need);
    st_d.first_rdy = st_q.lat_live && (st_q.lat_age == need);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{state: LSAT_IDLE, mem_ready: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign mem_ready       = st_q.mem_ready;
  assign agu_busy        = st_q.busy;
  assign use_stall       = st_q.stall;
  assign use_forwarded   = st_q.fwd;
  assign first_reg_ready = st_q.first_rdy;
  assign last_agu_cycles = st_q.last_cyc;

  // ==========================================================================
  // Checks
  property p_busy_no_ready;
    @(posedge clk) disable iff (!rst_n) agu_busy |-> !mem_ready;
  endproperty
  AST_BUSY_BLOCKS: assert property (p_busy_no_ready) else $error("Ready while busy");

  AST_ALIGNED_16: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && mem_op == LSAT_OP_LOAD_MULTIPLE && mem_reg_count == 5'h10 && mem_addr_aligned)
    |-> calc_cycles == 4'h8) else $error("Aligned 16 not 8");

  AST_UNALIGNED_16: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && mem_op == LSAT_OP_STORE_MULTIPLE && mem_reg_count == 5'h10 && !mem_addr_aligned)
    |-> calc_cycles == 4'h9) else $error("Unaligned 16 not 9");

  AST_PAIR_OPS: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && (mem_op == LSAT_OP_LOAD_DOUBLEWORD || mem_op == LSAT_OP_STORE_RETURN_STATE))
    |-> calc_cycles == (mem_addr_aligned ? 4'h1 : 4'h2)) else $error("Pair op timing");

  AST_SINGLE_SHIFT: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && mem_op == LSAT_OP_LOAD_SINGLE) |-> calc_cycles == (mem_offset_shift_reg ? 4'h2 : 4'h1))
    else $error("Single load cycles");

  AST_BUSY_SPAN: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && calc_cycles == 4'h3) |=> agu_busy [*2] ##1 !agu_busy) else $error("Busy span");

  AST_FAST_NEEDS_CLEAN: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && mem_sign_extend) |=> !st_q.fast_ok) else $error("Fast path after sign extend");

  AST_NO_FWD_SHIFT: assert property (@(posedge clk) disable iff (!rst_n)
    (use_valid && use_shift) |=> !use_forwarded) else $error("Forwarded to shifted use");

  AST_FIRST_READY: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && mem_op == LSAT_OP_LOAD_SINGLE && !mem_offset_shift_reg) ##1 (!accept) [*3]
    |-> $past(st_q.lat_age, 1) <= 3'h3) else $error("Latency age");

  COV_LM16: cover property (@(posedge clk) accept && mem_op == LSAT_OP_LOAD_MULTIPLE && mem_reg_count == 5'h10);
  COV_FWD: cover property (@(posedge clk) use_forwarded);
  COV_STALL: cover property (@(posedge clk) use_stall);

endmodule
`default_nettype wire

// >>> lsat_cycle_calc.sv
// Combinational cycle count for one memory operation in the generation unit.
// Assumes reg_count is 1..16 for multiples; other kinds ignore it.
`timescale 1ns/10ps
`default_nettype none
module lsat_cycle_calc
  import lsat_pkg::*;
(
  // Operation
  input  wire lsat_op_t   op,
  input  wire logic [4:0] reg_count,
  input  wire logic       addr_aligned,
  input  wire logic       offset_shift_reg,
  // Result
  output logic [3:0]      agu_cycles
);

  logic [4:0] regs;
  logic [4:0] tmp;

  always_comb begin
    regs = reg_count;
    tmp  = 5'h00;
    unique case (op)
      LSAT_OP_LOAD_DOUBLEWORD, LSAT_OP_RETURN_FROM_EXCEPTION,
      LSAT_OP_STORE_DOUBLEWORD, LSAT_OP_STORE_RETURN_STATE: begin
        regs = LSAT_PAIR_REGS;
      end
      default: begin
        regs = (reg_count > LSAT_MAX_REGS) ? LSAT_MAX_REGS : reg_count;
      end
    endcase
    if (op == LSAT_OP_LOAD_SINGLE || op == LSAT_OP_STORE_SINGLE) begin
      agu_cycles = offset_shift_reg ? LSAT_CYC_SHIFTREG : LSAT_CYC_SIMPLE;
    end else if (regs <= 5'h01) begin
      agu_cycles = LSAT_CYC_SIMPLE;
    end else if (addr_aligned) begin
      tmp = regs + 5'h01;
      agu_cycles = tmp[4:1];
    end else begin
      tmp = regs;
      agu_cycles = 4'(tmp[4:1] + 4'h1);
    end
    if (op == LSAT_OP_LOAD_SINGLE || op == LSAT_OP_STORE_SINGLE) begin
      tmp = 5'h00;
    end
  end

endmodule
`default_nettype wire

// >>> lsat_issue_model.sv
// Issue-stage model facing the timing block.
// Assumes the bench drives operation fields and holds them until taken.
`timescale 1ns/10ps
`default_nettype none
module lsat_issue_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench side
  input  wire logic req,
  output logic      taken,
  // Block side
  input  wire logic mem_ready,
  output logic      mem_valid
);
  // ==========================================================================
  // Request held until accepted; raised again on req even while unit busy, taken once ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid <= 1'b0;
      taken     <= 1'b0;
    end else begin
      taken <= mem_valid && mem_ready;
      if (mem_valid && mem_ready) begin
        mem_valid <= 1'b0;
      end else if (req) begin
        mem_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> lsat_pkg.sv
// Constants and types for the load/store address-generation timing block.
// Assumes a single core clock; issue stage presents one memory operation at a time.
//
// How it works
// - A fast forwarding path cuts the load-use latency by exactly one cycle.
// - Fast path only for arithmetic, logical or saturating consumers with no shift.
// - Fast path only for loads without sign extension and executed unconditionally.
// - Simple-addressed single loads take one generation cycle, latency 2 or 3.
// - Register-shifted or extend-rotated single loads take two cycles, latency 3 or 4.
// - Single load latency is measured to the first loaded destination register.
// - Two registers per cycle only at 64-bit aligned addresses.
// - Aligned load-multiple takes register count halved, rounded up, cycles.
// - Unaligned load-multiple takes 1 for one register, else count/2 plus one.
// - Load-multiple first register latency is 2 forwarded, 3 otherwise.
// - Doubleword load and exception return time like two-register load-multiple.
// - Store-multiple uses the same generation cycle counts as load-multiple.
// - Doubleword store and return-state store time like two-register store-multiple.
package lsat_pkg;

  // ==========================================================================
  // Operation kinds
  typedef enum logic [2:0] {
    LSAT_OP_LOAD_SINGLE,
    LSAT_OP_LOAD_MULTIPLE,
    LSAT_OP_STORE_MULTIPLE,
    LSAT_OP_LOAD_DOUBLEWORD,
    LSAT_OP_STORE_DOUBLEWORD,
    LSAT_OP_RETURN_FROM_EXCEPTION,
    LSAT_OP_STORE_RETURN_STATE,
    LSAT_OP_STORE_SINGLE
  } lsat_op_t;

  // ==========================================================================
  // Cycle figures
  localparam logic [3:0] LSAT_CYC_SIMPLE    = 4'h1;
  localparam logic [3:0] LSAT_CYC_SHIFTREG  = 4'h2;
  localparam logic [2:0] LSAT_LAT_SIMPLE    = 3'h3;
  localparam logic [2:0] LSAT_LAT_SHIFTREG  = 3'h4;
  localparam logic [2:0] LSAT_LAT_FAST_SAVE = 3'h1;
  localparam logic [4:0] LSAT_PAIR_REGS     = 5'h02;
  localparam logic [4:0] LSAT_MAX_REGS      = 5'h10;

endpackage

// >>> tb.sv
// Self-checking bench for the address-generation timing block.
// Assumes the issue model in lsat_issue_model.sv.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lsat_pkg::*;
  typedef struct {lsat_op_t op; logic al; logic sh; int ex;} lsat_row_t;
  logic clk, rst_n, req, taken, mem_valid, mem_ready, busy, stall, fwd, frr;
  logic al, sh, sx, cn, uv, ar, us;
  logic [4:0] cnt;
  logic [3:0] last;
  lsat_op_t op;
  int n_errors, samples_checked, lat, k, lt[5];
  logic seen;
  lsat_row_t rows[8];
  lsat_issue_model u_iss (.clk(clk), .rst_n(rst_n), .req(req), .taken(taken), .mem_ready(mem_ready),
    .mem_valid(mem_valid));
  lsat_agu_timing u_dut (.clk(clk), .rst_n(rst_n), .mem_valid(mem_valid), .mem_op(op), .mem_reg_count(cnt),
    .mem_addr_aligned(al), .mem_offset_shift_reg(sh), .mem_sign_extend(sx), .mem_conditional(cn),
    .use_valid(uv), .use_dependent(uv), .use_arith_logic_sat(ar), .use_shift(us), .mem_ready(mem_ready),
    .agu_busy(busy), .use_stall(stall), .use_forwarded(fwd), .first_reg_ready(frr), .last_agu_cycles(last));
  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // Issue one operation, return generation span and first-register latency
  task automatic issue(input lsat_op_t o, input int n, input logic a, input logic s, output int span);
    logic got;
    op = o; cnt = 5'(n); al = a; sh = s; req = 1'b1; span = 1; lat = 0; seen = 1'b0; got = 1'b0;
    @(posedge clk); #1 req = 1'b0;
    for (k = 0; k < 20 && !taken; k++) begin
      @(posedge clk); #1;
    end
    // The ready pulse lasts one cycle, so latency stops counting once it has been seen
    for (k = 0; k < 20 && !(mem_ready && (got || k > 6)); k++) begin
      seen |= fwd;
      got |= frr;
      if (!mem_ready) span++;
      if (!got) lat++;
      @(posedge clk); #1;
    end
    seen |= fwd;
  endtask
  // Aligned pairs two registers a cycle; unaligned leaves the first alone
  function automatic int want(input int n, input logic a);
    return a ? (n + 1) / 2 : (n == 1 ? 1 : n / 2 + 1);
  endfunction
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #60000;
    n_errors++;
    print_verdict();
  end
  initial begin
    int sp;
    rows = '{'{LSAT_OP_LOAD_SINGLE, 1, 0, 1}, '{LSAT_OP_LOAD_SINGLE, 1, 1, 2},
             '{LSAT_OP_LOAD_DOUBLEWORD, 1, 0, 1}, '{LSAT_OP_LOAD_DOUBLEWORD, 0, 0, 2},
             '{LSAT_OP_RETURN_FROM_EXCEPTION, 0, 0, 2}, '{LSAT_OP_STORE_DOUBLEWORD, 1, 0, 1},
             '{LSAT_OP_STORE_DOUBLEWORD, 0, 0, 2}, '{LSAT_OP_STORE_RETURN_STATE, 1, 0, 1}};
    {req, al, sh, sx, cn, uv, ar, us, n_errors, samples_checked} = '0;
    op = LSAT_OP_LOAD_SINGLE; cnt = 5'h01; rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({mem_ready, busy, stall, fwd, frr, 3'h0}, 8'h80);
    chk(8'(last), 8'h00);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].op, 2, rows[i].al, rows[i].sh, sp);
      chk(8'(last), 8'(rows[i].ex));
      chk(8'(sp), 8'(rows[i].ex));
    end
    $display("single and pair rows done");
    for (int n = 1; n <= 16; n++) begin
      for (int a = 0; a < 2; a++) begin
        issue(LSAT_OP_LOAD_MULTIPLE, n, a[0], 0, sp);
        chk(8'(sp), 8'(want(n, a[0])));
        chk(8'(lat), 8'(LSAT_LAT_SIMPLE));
        lt[0] = lat;
        issue(LSAT_OP_STORE_MULTIPLE, n, a[0], 0, sp);
        chk(8'(last), 8'(want(n, a[0])));
      end
    end
    $display("multiple sweep done");
    // Consumer class and producer traits: only the first row is fast
    for (int c = 0; c < 5; c++) begin
      uv = 1'b1; ar = (c != 3); us = (c == 4); sx = (c == 1); cn = (c == 2);
      issue(LSAT_OP_LOAD_SINGLE, 1, 1, 0, sp);
      lt[c] = lat;
      chk(8'(seen), 8'(c == 0));
      uv = 1'b0;
      repeat (4) @(posedge clk);
      #1;
    end
    chk(8'(lt[1] - lt[0]), 8'h01);
    issue(LSAT_OP_LOAD_SINGLE, 1, 1, 1, sp);
    chk(8'(lat - lt[1]), 8'h01);
    $display("forwarding tests done");
    // Reset in the middle of a long operation
    issue(LSAT_OP_LOAD_MULTIPLE, 16, 0, 0, sp);
    req = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b0; req = 1'b0;
    #1 chk({mem_ready, busy, fwd, frr}, 8'h08);
    @(posedge clk);
    #1 rst_n = 1'b1;
    issue(LSAT_OP_STORE_MULTIPLE, 3, 1, 0, sp);
    chk(8'(sp), 8'h02);
    $display("reset tests done");
    print_verdict();
  end
endmodule
`default_nettype wire
